//--- verilog/som_operating_mode_control.sv
// Operating-mode controller: mode state, supply gating, wake and watchdog.
`timescale 1ns/1ps
module som_operating_mode_control
(
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   input  wire logic                       word_done,
   input  wire logic [som_pkg::MODE_W-1:0] mode_select_bits,
   input  wire logic                       wd_on_cmd,
   input  wire logic [som_pkg::MON_N-1:0]  mon_in,
   input  wire logic                       lin_wake_in,
   input  wire logic                       lin_txd_in,
   input  wire logic                       wd_expired,
   input  wire logic                       reg_current_low,
   output som_pkg::som_mode_t              mode_state,
   output logic                            lin_tx_en,
   output logic                            lin_txd_out,
   output logic                            lin_rx_en,
   output logic                            lin_pullup_en,
   output logic                            lin_wake_en,
   output logic                            ldo_en,
   output logic                            switch_en,
   output logic                            osc_en,
   output logic                            rxd_low,
   output logic                            bus_wake_flag,
   output logic                            do_low,
   output logic                            wd_active,
   output logic                            wd_long_window,
   output logic                            mcu_reset
);

   // ============================================================
   // Wake detection
   som_wake_if wk ();

   som_wake_detect i_som_wake_detect
   (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .mon_in      (mon_in),
      .lin_wake_in (lin_wake_in),
      .wk          (wk)
   );

   // ============================================================
   // Command decode
   som_pkg::som_mode_t state;
   som_pkg::som_mode_t cmd_mode;
   som_pkg::som_mode_t next_state;
   logic               cmd_valid;
   logic               take_cmd;
   logic               in_sleep;
   logic               in_stop;
   logic               in_lin_sleep;
   logic               sleep_wake;
   logic               wd_sleep_reset;
   logic               lin_wake_stop;
   logic               lin_wake_lsl;
   logic               lin_wake_slp;
   logic               wd_on;
   logic [1:0]         do_count;

   // Standby has no code of its own, so it can never be commanded.
   always_comb
   begin
      cmd_mode  = som_pkg::SOM_STANDBY; // RULE3
      cmd_valid = 1'b1;
      case (mode_select_bits) // RULE1
         som_pkg::CODE_ACTIVE:    cmd_mode = som_pkg::SOM_ACTIVE;
         som_pkg::CODE_LIN_SLEEP: cmd_mode = som_pkg::SOM_LIN_SLEEP;
         som_pkg::CODE_RX_ONLY:   cmd_mode = som_pkg::SOM_RX_ONLY;
         som_pkg::CODE_STOP:      cmd_mode = som_pkg::SOM_STOP;
         som_pkg::CODE_SLEEP:     cmd_mode = som_pkg::SOM_SLEEP;
         default:                 cmd_valid = 1'b0; // RULE21
      endcase
   end

   assign take_cmd       = word_done && cmd_valid; // RULE22
   assign in_sleep       = (state == som_pkg::SOM_SLEEP);
   assign in_stop        = (state == som_pkg::SOM_STOP);
   assign in_lin_sleep   = (state == som_pkg::SOM_LIN_SLEEP);
   assign sleep_wake     = in_sleep && wk.any_wake; // RULE11
   assign wd_sleep_reset = in_sleep && wd_on && wd_expired; // RULE13
   assign lin_wake_stop  = in_stop && wk.lin_wake;
   assign lin_wake_lsl   = in_lin_sleep && wk.lin_wake;
   assign lin_wake_slp   = in_sleep && wk.lin_wake;

   // ============================================================
   // Mode state
   // A wake or watchdog event in Sleep outranks a command in the
   // same cycle, because the regulator is off and nothing can have
   // been sent by the microcontroller.
   always_comb
   begin
      next_state = state;
      if (sleep_wake || wd_sleep_reset)
         next_state = som_pkg::SOM_STANDBY; // RULE2
      else if (take_cmd)
         next_state = cmd_mode; // RULE4
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         state <= som_pkg::SOM_STANDBY; // RULE2
      else
         state <= next_state;
   end

   assign mode_state = state;

   // ============================================================
   // Supply and transceiver gating
   // Standby keeps the transceiver quiet until a mode is chosen.
   assign lin_tx_en     = (state == som_pkg::SOM_ACTIVE); // RULE5 RULE8 RULE9
   assign lin_rx_en     = (state == som_pkg::SOM_ACTIVE)
                       || (state == som_pkg::SOM_RX_ONLY); // RULE9
   assign lin_pullup_en = lin_rx_en; // RULE6 RULE19
   assign lin_txd_out   = lin_tx_en ? lin_txd_in : 1'b1; // RULE9
   assign lin_wake_en   = in_lin_sleep || in_stop || in_sleep; // RULE6
   assign ldo_en        = !in_sleep; // RULE10 RULE19
   assign switch_en     = !in_sleep; // RULE10
   assign osc_en        = !in_sleep || wd_on; // RULE15

   // ============================================================
   // Receive line and bus-wake flag
   // The flag is cleared by the next complete word, which carries
   // the status back; a new wake in that cycle wins.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rxd_low       <= 1'b0;
         bus_wake_flag <= 1'b0;
      end
      else
      begin
         if (lin_wake_lsl || lin_wake_slp || lin_wake_stop)
            rxd_low <= 1'b1; // RULE7 RULE12
         else if (take_cmd)
            rxd_low <= 1'b0;
         if (lin_wake_lsl || lin_wake_slp || lin_wake_stop)
            bus_wake_flag <= 1'b1; // RULE7
         else if (word_done)
            bus_wake_flag <= 1'b0;
      end
   end

   // ============================================================
   // Data-out notification
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         do_count <= som_pkg::DO_PULSE_ZERO;
      else if (lin_wake_stop)
         do_count <= som_pkg::DO_PULSE_LOAD; // RULE20
      else if (do_count != som_pkg::DO_PULSE_ZERO)
         do_count <= do_count - 2'h1;
   end

   assign do_low = (do_count != som_pkg::DO_PULSE_ZERO);

   // ============================================================
   // Watchdog on/off state
   // The state only follows the control bit of an accepted word; a
   // mode change alone never touches it, so it is inherited.
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         wd_on <= 1'b0; // RULE16
      else if (take_cmd)
         wd_on <= wd_on_cmd; // RULE13 RULE18
   end

   assign wd_active = wd_on && !reg_current_low; // RULE17

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wd_long_window <= 1'b0;
         mcu_reset      <= 1'b0;
      end
      else
      begin
         if (sleep_wake && !wd_on)
            wd_long_window <= 1'b1; // RULE14
         else if (take_cmd)
            wd_long_window <= 1'b0;
         mcu_reset <= wd_sleep_reset; // RULE13
      end
   end

   // ============================================================
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_lin_wake_in_stop;
      in_stop && wk.lin_wake;
   endsequence

   sequence s_do_pulse;
      do_low [*2] ##1 !do_low;
   endsequence

   sequence s_sleep_wake_plain;
      in_sleep && wk.any_wake && !wd_on;
   endsequence

   sequence s_standby_long;
      (state == som_pkg::SOM_STANDBY) && wd_long_window;
   endsequence

   a_reset_to_standby: assert property ( // RULE2
      $past(sys_rst) |-> state == som_pkg::SOM_STANDBY)
      else $error("Controller left reset outside Standby.");

   a_never_cmd_standby: assert property ( // RULE3
      $rose(state == som_pkg::SOM_STANDBY) |->
         $past(sleep_wake) || $past(wd_sleep_reset))
      else $error("Standby entered without a wake or watchdog cause.");

   a_cmd_applied: assert property ( // RULE1
      (take_cmd && !sleep_wake && !wd_sleep_reset) |=>
         state == $past(cmd_mode))
      else $error("Accepted mode command was not applied.");

   a_bad_code_hold: assert property ( // RULE21
      (word_done && !cmd_valid && !sleep_wake && !wd_sleep_reset)
         |=> $stable(state))
      else $error("Unmapped mode code changed the mode.");

   a_rx_only_tx_off: assert property ( // RULE9
      state == som_pkg::SOM_RX_ONLY |->
         !lin_tx_en && lin_rx_en && lin_txd_out)
      else $error("Receive-only mode did not block transmit.");

   a_lin_sleep_off: assert property ( // RULE6
      in_lin_sleep |-> !lin_tx_en && !lin_rx_en && !lin_pullup_en
         && lin_wake_en)
      else $error("LIN-sleep left the transceiver on.");

   a_lin_sleep_wake: assert property ( // RULE7
      (lin_wake_lsl && !take_cmd) |=> rxd_low && bus_wake_flag && in_lin_sleep)
      else $error("LIN wake in LIN-sleep not reported.");

   a_sleep_all_off: assert property ( // RULE10
      in_sleep |-> !ldo_en && !switch_en && !lin_tx_en && !lin_rx_en)
      else $error("Sleep left a supply or switch on.");

   a_sleep_wake_back: assert property ( // RULE11
      sleep_wake |=> state == som_pkg::SOM_STANDBY && ldo_en)
      else $error("Sleep wake did not return to Standby.");

   a_stop_keeps_ldo: assert property ( // RULE19
      in_stop |-> ldo_en && !lin_pullup_en && !lin_rx_en)
      else $error("Stop gating wrong.");

   a_do_two_cycles: assert property ( // RULE20
      s_lin_wake_in_stop ##1 (!wk.lin_wake) [*3] |->
         $past(do_low, 2) && $past(do_low) && !do_low)
      else $error("Data-out wake pulse length wrong.");

   a_do_pulse_form: assert property ( // RULE20
      (s_lin_wake_in_stop ##1 !(in_stop && wk.lin_wake) [*2]) |=>
         !do_low)
      else $error("Data-out pulse longer than two cycles.");

   a_long_window: assert property ( // RULE14
      s_sleep_wake_plain |=> s_standby_long)
      else $error("Long open window missing after Sleep wake.");

   a_wd_current_low: assert property ( // RULE17
      reg_current_low |-> !wd_active)
      else $error("Watchdog active below current threshold.");

   a_wd_reset_sleep: assert property ( // RULE13
      (in_sleep && wd_on && wd_expired) |=>
         mcu_reset && state == som_pkg::SOM_STANDBY)
      else $error("Watchdog in Sleep did not reset to Standby.");

   a_osc_in_sleep: assert property ( // RULE15
      (in_sleep && wd_on) |-> osc_en)
      else $error("Oscillator stopped in watched Sleep.");

   a_wd_inherit: assert property ( // RULE16
      (state != $past(state) && !$past(take_cmd)) |-> $stable(wd_on))
      else $error("Watchdog state changed without a command.");

   a_rxd_held: assert property ( // RULE12
      (rxd_low && !take_cmd && !sys_rst) |=> rxd_low)
      else $error("Receive line released before a mode command.");

   // The checks below pin down mode outputs, reset values and what must not move between complete words.
   a_active_both_on: assert property ( // RULE5
      (state == som_pkg::SOM_ACTIVE) |->
         lin_tx_en && lin_rx_en && lin_pullup_en && (lin_txd_out == lin_txd_in))
      else $error("Active mode did not enable the transceiver.");

   a_tx_stays_off: assert property ( // RULE8
      (!lin_tx_en && !take_cmd) |=> !lin_tx_en)
      else $error("Transmitter enabled without a mode command.");

   a_sleep_lin_rxd: assert property ( // RULE12
      lin_wake_slp |=> rxd_low && state == som_pkg::SOM_STANDBY)
      else $error("LIN wake from Sleep did not hold the receive line low.");

   a_wd_off_reset: assert property ( // RULE16
      $past(sys_rst) |-> !wd_active)
      else $error("Watchdog left on after reset.");

   a_wd_follows_word: assert property ( // RULE13
      take_cmd |=> wd_on == $past(wd_on_cmd))
      else $error("Watchdog bit of an accepted word was not taken.");

   a_no_word_hold: assert property ( // RULE22
      (!word_done && !sleep_wake && !wd_sleep_reset) |=>
         $stable(state) && $stable(wd_on))
      else $error("Mode or watchdog state moved without a complete word.");

   a_flag_wake_wins: assert property ( // RULE7
      (word_done && wk.lin_wake && lin_wake_en) |=> bus_wake_flag)
      else $error("Bus wake flag lost to a clear in the same cycle.");

   a_flag_cleared: assert property ( // RULE7
      (word_done && !wk.lin_wake) |=> !bus_wake_flag)
      else $error("Bus wake flag not cleared by a complete word.");

   a_standby_quiet: assert property ( // RULE2
      (state == som_pkg::SOM_STANDBY) |->
         !lin_tx_en && !lin_rx_en && ldo_en && switch_en)
      else $error("Standby did not keep the transceiver off and supplies on.");

   a_stop_stays: assert property ( // RULE19
      (in_stop && wk.any_wake && !take_cmd) |=> in_stop)
      else $error("Wake event moved the controller out of Stop.");

   a_osc_off_unwatched: assert property ( // RULE18
      (in_sleep && !wd_on) |-> !osc_en && !wd_active)
      else $error("Unwatched Sleep kept the oscillator or watchdog running.");

   a_reset_one_cycle: assert property ( // RULE13
      mcu_reset |=> !mcu_reset)
      else $error("Watchdog reset pulse longer than one cycle.");

endmodule // som_operating_mode_control

//--- verilog/som_pkg.sv
// Constants, mode codes and state type of the operating-mode controller.
// Operation
// RULE1: Three mode-select bits choose the operating mode.
// RULE2: Power-up or wake-up enters Standby automatically.
// RULE3: Standby cannot be commanded; only left.
// RULE4: Standby may go straight to Stop/Sleep.
// RULE5: Active enables transmit and receive; has LIN-sleep.
// RULE6: LIN-sleep disables transceiver, pull-up; wake stays.
// RULE7: LIN wake in LIN-sleep: receive low, flag.
// RULE8: Transceiver stays off until Active is commanded; the code also turns the receiver on for a Receive-only command.
// RULE9: Receive-only blocks transmit, keeps receiver running.
// RULE10: Sleep turns off transceiver, regulator and switches.
// RULE11: Sleep wake-up enters Standby, regulator back on.
// RULE12: LIN wake from Sleep holds receive low.
// RULE13: Watchdog in Sleep optional; resets into Standby.
// RULE14: Unwatched Sleep wakes with long open window.
// RULE15: Watched Sleep keeps the oscillator running.
// RULE16: Watchdog state carried over; off after reset.
// RULE17: Low regulator current forces watchdog off.
// RULE18: Watchdog defaults off in Stop and Sleep.
// RULE19: Stop disables transceiver, termination; regulator stays.
// RULE20: LIN wake in Stop pulls data-out low briefly.
// RULE21: Unmapped mode codes leave the mode unchanged.
// RULE22: Mode bits taken only on complete serial word.
package som_pkg;

   // ============================================================
   // Widths
   localparam int MODE_W = 3;
   localparam int MON_N  = 5;

   // ============================================================
   // Mode-select codes
   localparam logic [MODE_W-1:0] CODE_ACTIVE    = 3'h1;
   localparam logic [MODE_W-1:0] CODE_LIN_SLEEP = 3'h2;
   localparam logic [MODE_W-1:0] CODE_RX_ONLY   = 3'h3;
   localparam logic [MODE_W-1:0] CODE_STOP      = 3'h4;
   localparam logic [MODE_W-1:0] CODE_SLEEP     = 3'h5;

   // ============================================================
   // Timing
   localparam int          DO_PULSE_CYCLES = 2;
   localparam logic [1:0]  DO_PULSE_LOAD   = 2'(DO_PULSE_CYCLES);
   localparam logic [1:0]  DO_PULSE_ZERO   = 2'h0;
   localparam logic [MON_N-1:0] MON_RESET  = 5'h00;

   typedef enum logic [2:0] {
      SOM_STANDBY,
      SOM_ACTIVE,
      SOM_LIN_SLEEP,
      SOM_RX_ONLY,
      SOM_STOP,
      SOM_SLEEP
   } som_mode_t;

endpackage

//--- verilog/som_wake_if.sv
// Wake-event signals between the wake detector and the mode controller.
`timescale 1ns/1ps
interface som_wake_if;
   logic mon_change;
   logic lin_wake;
   logic any_wake;
   modport detector (output mon_change, output lin_wake, output any_wake);
   modport control  (input  mon_change, input  lin_wake, input  any_wake);
endinterface

//--- verilog/som_wake_detect.sv
// Wake detector: level change on monitor inputs and LIN wake events.
`timescale 1ns/1ps
module som_wake_detect
(
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire logic [som_pkg::MON_N-1:0] mon_in,
   input  wire logic                      lin_wake_in,
   som_wake_if.detector                   wk
);

   // ============================================================
   // Monitor history
   // The first sample after reset only primes the history, so a
   // monitor that idles high does not look like a wake-up.
   logic [som_pkg::MON_N-1:0] mon_prev;
   logic                      primed;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         mon_prev <= som_pkg::MON_RESET;
         primed   <= 1'b0;
      end
      else
      begin
         mon_prev <= mon_in;
         primed   <= 1'b1;
      end
   end

   assign wk.mon_change = primed && (mon_in != mon_prev);
   assign wk.lin_wake   = lin_wake_in;
   assign wk.any_wake   = wk.mon_change || lin_wake_in;

endmodule // som_wake_detect

//--- verification/som_mcu_model.sv
// Microcontroller model that sends complete serial control words to the mode controller.
`timescale 1ns/1ps
module som_mcu_model
(
   input  wire logic                       clk,
   output logic                            word_done,
   output logic [som_pkg::MODE_W-1:0]      mode_select_bits,
   output logic                            wd_on_cmd
);

   // ============================================================
   // Word driver
   initial
   begin
      word_done        = 1'b0;
      mode_select_bits = 3'h7;
      wd_on_cmd        = 1'b0;
   end

   // Between words the bits show the inverse of the last word, so a design that
   // samples them without the word strobe picks up a different mode.
   task automatic send_word(input logic [som_pkg::MODE_W-1:0] code, input logic wd_on);
      @(negedge clk);
      word_done        = 1'b1;
      mode_select_bits = code;
      wd_on_cmd        = wd_on;
      @(negedge clk);
      word_done        = 1'b0;
      mode_select_bits = ~code;
      wd_on_cmd        = ~wd_on;
   endtask

endmodule // som_mcu_model

//--- verification/som_operating_mode_control_bench.sv
// Self-checking testbench of the operating-mode controller.
`timescale 1ns/1ps
module som_operating_mode_control_bench;
   logic                       clk = 1'b0;
   logic                       sys_rst = 1'b1;
   logic [som_pkg::MON_N-1:0]  mon_in = 5'h00;
   logic                       lin_wake_in = 1'b0, lin_txd_in = 1'b1;
   logic                       wd_expired = 1'b0, reg_current_low = 1'b0;
   logic                       word_done, wd_on_cmd;
   logic [som_pkg::MODE_W-1:0] mode_select_bits;
   som_pkg::som_mode_t         mode_state;
   logic                       lin_tx_en, lin_txd_out, lin_rx_en, lin_pullup_en, lin_wake_en;
   logic                       ldo_en, switch_en, osc_en, rxd_low, bus_wake_flag, do_low;
   logic                       wd_active, wd_long_window, mcu_reset;
   int                         err_count = 0;
   int                         checks = 0;

   always #5 clk = ~clk;

   som_mcu_model i_som_mcu_model (.clk, .word_done, .mode_select_bits, .wd_on_cmd);

   som_operating_mode_control i_som_operating_mode_control
   (
      .clk, .sys_rst, .word_done, .mode_select_bits, .wd_on_cmd, .mon_in, .lin_wake_in,
      .lin_txd_in, .wd_expired, .reg_current_low, .mode_state, .lin_tx_en, .lin_txd_out,
      .lin_rx_en, .lin_pullup_en, .lin_wake_en, .ldo_en, .switch_en, .osc_en, .rxd_low,
      .bus_wake_flag, .do_low, .wd_active, .wd_long_window, .mcu_reset
   );

   // ============================================================
   // Helpers
   task automatic chk(input string what, input logic e, input logic g);
      checks++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR %s expected %b seen %b", what, e, g);
      end
   endtask

   task automatic chkm(input som_pkg::som_mode_t e);
      checks++;
      if (mode_state !== e)
      begin
         err_count++;
         $display("ERROR mode_state expected %0d seen %0d", e, mode_state);
      end
   endtask

   task automatic word(input logic [som_pkg::MODE_W-1:0] c, input logic w);
      i_som_mcu_model.send_word(c, w);
   endtask

   // Called at a falling edge; the wake is taken at the rising edge in between.
   task automatic wake_lin();
      lin_wake_in = 1'b1;
      @(negedge clk);
      lin_wake_in = 1'b0;
   endtask

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ============================================================
   // Watchdog: the tests need under a hundred cycles only.
   initial
   begin
      #100000;
      err_count++;
      give_verdict();
   end

   // ============================================================
   // Tests
   initial
   begin
      repeat (20) @(negedge clk);
      sys_rst = 1'b0;
      chkm(som_pkg::SOM_STANDBY);
      chk("wd_active", 1'b0, wd_active);
      chk("ldo_en", 1'b1, ldo_en);
      $display("Test reset done");

      word(som_pkg::CODE_ACTIVE, 1'b0);
      chkm(som_pkg::SOM_ACTIVE);
      chk("lin_tx_en", 1'b1, lin_tx_en);
      chk("lin_rx_en", 1'b1, lin_rx_en);
      chk("lin_pullup_en", 1'b1, lin_pullup_en);
      lin_txd_in = 1'b0;
      #1 chk("lin_txd_out", 1'b0, lin_txd_out);
      repeat (3) @(negedge clk);
      chkm(som_pkg::SOM_ACTIVE);
      word(3'h0, 1'b1);
      chkm(som_pkg::SOM_ACTIVE);
      word(3'h6, 1'b1);
      chkm(som_pkg::SOM_ACTIVE);
      word(3'h7, 1'b1);
      chkm(som_pkg::SOM_ACTIVE);
      chk("wd_active", 1'b0, wd_active);
      word(som_pkg::CODE_RX_ONLY, 1'b0);
      chk("lin_tx_en", 1'b0, lin_tx_en);
      chk("lin_txd_out", 1'b1, lin_txd_out);
      chk("lin_rx_en", 1'b1, lin_rx_en);
      // The idle bits now show the Stop code; only a complete word may act on them.
      repeat (2) @(negedge clk);
      chkm(som_pkg::SOM_RX_ONLY);
      $display("Test modes done");

      word(som_pkg::CODE_LIN_SLEEP, 1'b0);
      chk("lin_rx_en", 1'b0, lin_rx_en);
      chk("lin_pullup_en", 1'b0, lin_pullup_en);
      chk("lin_wake_en", 1'b1, lin_wake_en);
      wake_lin();
      chk("rxd_low", 1'b1, rxd_low);
      chk("bus_wake_flag", 1'b1, bus_wake_flag);
      chkm(som_pkg::SOM_LIN_SLEEP);
      repeat (2) @(negedge clk);
      chk("lin_tx_en", 1'b0, lin_tx_en);
      word(som_pkg::CODE_ACTIVE, 1'b0);
      chk("lin_tx_en", 1'b1, lin_tx_en);
      chk("rxd_low", 1'b0, rxd_low);
      chk("bus_wake_flag", 1'b0, bus_wake_flag);
      $display("Test lin sleep done");

      word(som_pkg::CODE_STOP, 1'b0);
      chk("ldo_en", 1'b1, ldo_en);
      chk("lin_pullup_en", 1'b0, lin_pullup_en);
      chk("lin_tx_en", 1'b0, lin_tx_en);
      wake_lin();
      chk("do_low c1", 1'b1, do_low);
      @(negedge clk);
      chk("do_low c2", 1'b1, do_low);
      @(negedge clk);
      chk("do_low c3", 1'b0, do_low);
      $display("Test stop done");

      word(som_pkg::CODE_SLEEP, 1'b0);
      chk("ldo_en", 1'b0, ldo_en);
      chk("switch_en", 1'b0, switch_en);
      chk("lin_rx_en", 1'b0, lin_rx_en);
      chk("osc_en", 1'b0, osc_en);
      mon_in = 5'h04;
      @(negedge clk);
      chkm(som_pkg::SOM_STANDBY);
      chk("ldo_en", 1'b1, ldo_en);
      chk("wd_long_window", 1'b1, wd_long_window);
      $display("Test sleep monitor wake done");

      word(som_pkg::CODE_ACTIVE, 1'b1);
      chk("wd_active", 1'b1, wd_active);
      reg_current_low = 1'b1;
      #1 chk("wd_active", 1'b0, wd_active);
      @(negedge clk);
      reg_current_low = 1'b0;
      word(som_pkg::CODE_SLEEP, 1'b1);
      chk("osc_en", 1'b1, osc_en);
      chk("wd_active", 1'b1, wd_active);
      wd_expired = 1'b1;
      @(negedge clk);
      wd_expired = 1'b0;
      chk("mcu_reset", 1'b1, mcu_reset);
      chkm(som_pkg::SOM_STANDBY);
      chk("wd_long_window", 1'b0, wd_long_window);
      @(negedge clk);
      chk("mcu_reset", 1'b0, mcu_reset);
      $display("Test watchdog done");

      sys_rst = 1'b1;
      @(negedge clk);
      sys_rst = 1'b0;
      chkm(som_pkg::SOM_STANDBY);
      chk("wd_active", 1'b0, wd_active);
      $display("Test mid-run reset done");

      word(som_pkg::CODE_SLEEP, 1'b0);
      wake_lin();
      chkm(som_pkg::SOM_STANDBY);
      repeat (3) @(negedge clk);
      chk("rxd_low", 1'b1, rxd_low);
      word(som_pkg::CODE_ACTIVE, 1'b0);
      chk("rxd_low", 1'b0, rxd_low);
      $display("Test sleep lin wake done");
      give_verdict();
   end

endmodule // som_operating_mode_control_bench
